// ---- sim/drc_error_counters_checker.sv ----
// concurrent checks on the receive error counter bank ports
`timescale 1ns/1ps
module drc_error_counters_checker (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_w_taken;
    s_axi_awready && s_axi_wready;
  endsequence
  ar_to_r_a: assert property (s_ar_taken |=> s_axi_rvalid)
    else $error("read data late");
  w_to_b_a: assert property (s_w_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  ar_pulse_a: assert property (s_axi_arready |=> !s_axi_arready)
    else $error("arready held");
  r_width_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("count wider than sixteen bits");
  slverr_zero_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  irq_reset_a: assert property ($fell(reset) |-> !irq)
    else $error("irq high after reset");
endmodule
bind drc_error_counters drc_error_counters_checker u_drc_error_counters_checker (.*);

// ---- sim/drc_error_counters_tb.sv ----
// testbench of the receive error counter bank
`timescale 1ns/1ps
`include "drc_defs.svh"
module drc_error_counters_tb;
  logic clk = 0, reset = 1, perf_monitor_update = 0;
  logic framing_err_cnt, p_parity_err_cnt, far_block_err_cnt, c_parity_err_cnt, irq;
  logic [3:0] req = 0, s_axi_wstrb = 4'hF;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  int errors = 0, checked = 0, cyc = 0, i;
  always #12.5 clk = ~clk;
  drc_error_counters u_drc_error_counters (.*);
  drc_framer_model u_drc_framer_model (.*);
  task stop_test;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      stop_test;
    end
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  function automatic logic [11:0] byte_addr(input logic [11:0] idx);
    byte_addr = {idx[9:0], 2'b00};
  endfunction
  task wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task rd(input logic [11:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  task rc(input logic [11:0] a, input logic [31:0] e);
    rd(a);
    chk($sformatf("reg %h", a), e, d);
  endtask
  task fire(input logic [3:0] m, input int n);
    req <= m;
    repeat (2 * n) @(posedge clk);
    req <= 4'h0;
    repeat (4) @(posedge clk);
  endtask
  task upd;
    perf_monitor_update <= 1;
    repeat (2) @(posedge clk);
    perf_monitor_update <= 0;
    repeat (6) @(posedge clk);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    reset <= 0;
    for (i = 0; i < 4; i++) rc(byte_addr(`DRC_OFF_FRAMING + 12'(i * 2)), 32'h0);
    rd(12'h4D2);
    chk("misaligned resp", 32'(2'h2), 32'(r));
    wr(12'h7C0, 32'h1);
    chk("unmapped wr resp", 32'(2'h2), 32'(r));
    $display("test reset done");
    fire(4'hF, 1);
    fire(4'h9, 2);
    rc(byte_addr(`DRC_OFF_FRAMING), 32'h0);
    upd;
    rc(byte_addr(`DRC_OFF_FRAMING), 32'h3);
    rc(byte_addr(`DRC_OFF_P_PARITY), 32'h1);
    rc(byte_addr(`DRC_OFF_FAR_BLOCK), 32'h1);
    rc(byte_addr(`DRC_OFF_C_PARITY), 32'h3);
    upd;
    rc(byte_addr(`DRC_OFF_FRAMING), 32'h0);
    $display("test counting done");
    wr(byte_addr(`DRC_OFF_CONTROL), 32'h1);
    fire(4'hF, 2);
    upd;
    rc(byte_addr(`DRC_OFF_FRAMING), 32'h2);
    rc(byte_addr(`DRC_OFF_P_PARITY), 32'h2);
    rc(byte_addr(`DRC_OFF_FAR_BLOCK), 32'h0);
    rc(byte_addr(`DRC_OFF_C_PARITY), 32'h0);
    $display("test m23 done");
    rc(byte_addr(`DRC_OFF_STATUS), 32'hF);
    wr(byte_addr(`DRC_OFF_ENABLE), 32'h1);
    repeat (3) @(posedge clk);
    chk("irq port off", 32'h0, 32'(irq));
    wr(byte_addr(`DRC_OFF_CONTROL), 32'h3);
    repeat (3) @(posedge clk);
    chk("irq on", 32'h1, 32'(irq));
    wr(byte_addr(`DRC_OFF_STATUS), 32'hF);
    repeat (3) @(posedge clk);
    chk("irq cleared", 32'h0, 32'(irq));
    $display("test irq done");
    stop_test;
  end
endmodule

// ---- sim/drc_framer_model.sv ----
// receive framer model producing error event pulses
`timescale 1ns/1ps
module drc_framer_model (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [3:0] req,
  output logic            framing_err_cnt,
  output logic            p_parity_err_cnt,
  output logic            far_block_err_cnt,
  output logic            c_parity_err_cnt
);
  logic [3:0] evt;
  assign {c_parity_err_cnt, far_block_err_cnt, p_parity_err_cnt, framing_err_cnt} = evt;
  always_ff @(posedge clk) begin
    if (reset) begin
      evt <= 4'h0;
    end else begin
      evt <= req & ~evt;
    end
  end
endmodule

// ---- verilog/drc_counter.sv ----
// one saturating error accumulator with a snapshot register
`timescale 1ns/1ps
`include "drc_defs.svh"
module drc_counter
  import drc_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     reset,
  input  wire logic     event_pulse,
  input  wire logic     count_enable,
  input  wire logic     update,
  output drc_cnt_t      snapshot_reg
);
  drc_cnt_t acc_reg;
  drc_cnt_t acc_next;

  always_comb begin
    acc_next = acc_reg;
    if (event_pulse && count_enable && acc_reg != `DRC_CNT_MAX) begin
      acc_next = acc_reg + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      acc_reg <= `DRC_CNT_RESET;
    end else if (update) begin
      // restart from zero, keeping an event of the same cycle
      acc_reg <= (event_pulse && count_enable) ? 16'h0001 : `DRC_CNT_RESET;
    end else begin
      acc_reg <= acc_next;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      snapshot_reg <= `DRC_CNT_RESET;
    end else if (update) begin
      snapshot_reg <= acc_reg;
    end
  end
endmodule

// ---- verilog/drc_defs.svh ----
// register word indexes, field positions and reset values of the receive error counters
`ifndef DRC_DEFS_SVH
`define DRC_DEFS_SVH
`define DRC_OFF_FRAMING      12'h134
`define DRC_OFF_P_PARITY     12'h136
`define DRC_OFF_FAR_BLOCK    12'h138
`define DRC_OFF_C_PARITY     12'h13A
`define DRC_OFF_STATUS       12'h140
`define DRC_OFF_ENABLE       12'h144
`define DRC_OFF_CONTROL      12'h148
`define DRC_CNT_RESET        16'h0000
`define DRC_CNT_MAX          16'hFFFF
`define DRC_FLAG_RESET       4'h0
`define DRC_CTRL_M23_BIT     0
`define DRC_CTRL_PORT_EN_BIT 1
`define DRC_CTRL_RESET       2'h0
`define DRC_ADDR_W           12
`define DRC_IDX_FRAMING      0
`define DRC_IDX_P_PARITY     1
`define DRC_IDX_FAR_BLOCK    2
`define DRC_IDX_C_PARITY     3
`define DRC_RESP_OKAY        2'h0
`define DRC_RESP_SLVERR      2'h2
`endif

// ---- verilog/drc_error_counters.sv ----
// receive error counter bank with AXI4-Lite register slave and interrupt
// How it works
// - framing error events counted in a sixteen-bit register
// - P-bit parity errors counted in a sixteen-bit register
// - far-end block errors counted in a sixteen-bit register
// - C-bit parity errors counted in a sixteen-bit register
// - in M23 format the far-end and C-bit counters do not count
// - readable counts change only on a performance monitor update
// - P-bit count at 136h, C-bit count at 13Ah, reset to zero
// - framing count at 134h, resets to zero
// - per-counter latched flag, interrupt when counter and port enables set
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
`include "drc_defs.svh"
module drc_error_counters
  import drc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        framing_err_cnt,
  input  wire logic        p_parity_err_cnt,
  input  wire logic        far_block_err_cnt,
  input  wire logic        c_parity_err_cnt,
  input  wire logic        perf_monitor_update,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             irq
);
  // ****************************************
  // event inputs and control
  // ****************************************
  logic [3:0]  ev_meta_reg;
  logic [3:0]  ev_sync_reg;
  logic [3:0]  ev_prev_reg;
  logic [3:0]  ev_pulse;
  logic        upd_meta_reg;
  logic        upd_sync_reg;
  logic        upd_prev_reg;
  logic        update;
  logic [1:0]  control_reg;
  logic [3:0]  enable_reg;
  logic [3:0]  flag_reg;
  logic [3:0]  count_en;
  drc_cnt_t    snap [4];
  logic        m23_mode;

  // event synchroniser and edge detect
  always_ff @(posedge clk) begin
    if (reset) begin
      ev_meta_reg <= 4'h0;
      ev_sync_reg <= 4'h0;
      ev_prev_reg <= 4'h0;
    end else begin
      ev_meta_reg <= {c_parity_err_cnt, far_block_err_cnt, p_parity_err_cnt, framing_err_cnt};
      ev_sync_reg <= ev_meta_reg;
      ev_prev_reg <= ev_sync_reg;
    end
  end

  // update synchroniser and edge detect
  always_ff @(posedge clk) begin
    if (reset) begin
      upd_meta_reg <= 1'b0;
      upd_sync_reg <= 1'b0;
      upd_prev_reg <= 1'b0;
    end else begin
      upd_meta_reg <= perf_monitor_update;
      upd_sync_reg <= upd_meta_reg;
      upd_prev_reg <= upd_sync_reg;
    end
  end

  assign ev_pulse = ev_sync_reg & ~ev_prev_reg;
  assign update   = upd_sync_reg & ~upd_prev_reg;
  assign m23_mode = control_reg[`DRC_CTRL_M23_BIT];
  assign count_en = {~m23_mode, ~m23_mode, 1'b1, 1'b1};

  // ****************************************
  // counters
  // ****************************************
  // four sixteen-bit counters
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_cnt
      drc_counter u_cnt (
        .clk          (clk),
        .reset        (reset),
        .event_pulse  (ev_pulse[gi]),
        .count_enable (count_en[gi]),
        .update       (update),
        .snapshot_reg (snap[gi])
      );
    end
  endgenerate

  // ****************************************
  // register slave
  // ****************************************
  drc_wstate_e wstate_reg;
  logic [11:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        aw_have_reg;
  logic        w_have_reg;
  logic        wr_fire;
  logic        wr_ok;
  logic        wr_ctrl_hit;
  logic        wr_enab_hit;
  logic        wr_stat_hit;
  logic [3:0]  flag_set;
  logic [3:0]  flag_clr;

  // word index of a byte address, all ones when misaligned
  function automatic logic [11:0] reg_index(input logic [11:0] a);
    reg_index = (a[1:0] == 2'b00) ? {2'b00, a[11:2]} : 12'hFFF;
  endfunction

  function automatic logic addr_known(input logic [11:0] a);
    case (a)
      `DRC_OFF_FRAMING, `DRC_OFF_P_PARITY, `DRC_OFF_FAR_BLOCK, `DRC_OFF_C_PARITY,
      `DRC_OFF_STATUS, `DRC_OFF_ENABLE, `DRC_OFF_CONTROL: addr_known = 1'b1;
      default: addr_known = 1'b0;
    endcase
  endfunction

  assign wr_fire = (wstate_reg == DRC_W_IDLE) && aw_have_reg && w_have_reg;
  assign wr_ok   = addr_known(reg_index(awaddr_reg));

  // write strobes per register, low byte lane only
  assign wr_ctrl_hit = wr_fire && wstrb_reg[0] && (reg_index(awaddr_reg) == `DRC_OFF_CONTROL);
  assign wr_enab_hit = wr_fire && wstrb_reg[0] && (reg_index(awaddr_reg) == `DRC_OFF_ENABLE);
  assign wr_stat_hit = wr_fire && wstrb_reg[0] && (reg_index(awaddr_reg) == `DRC_OFF_STATUS);

  // write address capture
  always_ff @(posedge clk) begin
    if (reset) begin
      aw_have_reg   <= 1'b0;
      awaddr_reg    <= 12'h000;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end else if (!aw_have_reg && s_axi_awvalid && wstate_reg == DRC_W_IDLE) begin
        s_axi_awready <= 1'b1;
      end
      if (wr_fire) begin
        aw_have_reg <= 1'b0;
      end
    end
  end

  // write data capture
  always_ff @(posedge clk) begin
    if (reset) begin
      w_have_reg   <= 1'b0;
      wdata_reg    <= 32'h00000000;
      wstrb_reg    <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end else if (!w_have_reg && s_axi_wvalid && wstate_reg == DRC_W_IDLE) begin
        s_axi_wready <= 1'b1;
      end
      if (wr_fire) begin
        w_have_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wstate_reg   <= DRC_W_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `DRC_RESP_OKAY;
    end else begin
      case (wstate_reg)
        DRC_W_IDLE: begin
          if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? `DRC_RESP_OKAY : `DRC_RESP_SLVERR;
            wstate_reg   <= DRC_W_RESP;
          end
        end
        DRC_W_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            wstate_reg   <= DRC_W_IDLE;
          end
        end
        default: begin
          wstate_reg   <= DRC_W_IDLE;
          s_axi_bvalid <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // control, flags and interrupt
  // ****************************************
  // m23 mode and port enable
  always_ff @(posedge clk) begin
    if (reset) begin
      control_reg <= `DRC_CTRL_RESET;
    end else if (wr_ctrl_hit) begin
      control_reg <= wdata_reg[1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      enable_reg <= `DRC_FLAG_RESET;
    end else if (wr_enab_hit) begin
      enable_reg <= wdata_reg[3:0];
    end
  end

  assign flag_set = ev_pulse & count_en;
  assign flag_clr = wr_stat_hit ? wdata_reg[3:0] : 4'h0;

  // latched flags, set wins over clear
  always_ff @(posedge clk) begin
    if (reset) begin
      flag_reg <= `DRC_FLAG_RESET;
    end else begin
      flag_reg <= (flag_reg & ~flag_clr) | flag_set;
    end
  end

  // interrupt gated by counter and port enables
  always_ff @(posedge clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= control_reg[`DRC_CTRL_PORT_EN_BIT] && |(flag_reg & enable_reg);
    end
  end

  // ****************************************
  // read channel
  // ****************************************
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    case (reg_index(s_axi_araddr))
      `DRC_OFF_FRAMING:   rd_mux = {16'h0000, snap[`DRC_IDX_FRAMING]};
      `DRC_OFF_P_PARITY:  rd_mux = {16'h0000, snap[`DRC_IDX_P_PARITY]};
      `DRC_OFF_FAR_BLOCK: rd_mux = {16'h0000, snap[`DRC_IDX_FAR_BLOCK]};
      `DRC_OFF_C_PARITY:  rd_mux = {16'h0000, snap[`DRC_IDX_C_PARITY]};
      `DRC_OFF_STATUS:    rd_mux = {28'h0000000, flag_reg};
      `DRC_OFF_ENABLE:    rd_mux = {28'h0000000, enable_reg};
      `DRC_OFF_CONTROL:   rd_mux = {30'h00000000, control_reg};
      default:            rd_mux = 32'h00000000;
    endcase
  end

  // read handshake
  always_ff @(posedge clk) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
      end else if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

  // read data and response capture
  always_ff @(posedge clk) begin
    if (reset) begin
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `DRC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= addr_known(reg_index(s_axi_araddr)) ? `DRC_RESP_OKAY : `DRC_RESP_SLVERR;
    end
  end
endmodule

// ---- verilog/drc_pkg.sv ----
// types shared by the receive error counter bank
package drc_pkg;
  typedef logic [15:0] drc_cnt_t;
  typedef enum logic [1:0] {
    DRC_W_IDLE,
    DRC_W_RESP
  } drc_wstate_e;
endpackage
